// [core/micsq_seq.sv]
// Calibration sequencer for a memory interface PHY.
// How it works
// - DDR3/DDR4 level chip-select and command bus
// - DDR4/QDR-IV deskew command bus, one shared delay
// - Leveling toggles select and CAS, watches strobe
// - DDR4 deskew drives parity, alert confirms
// - Deskew leaves termination, clock-enable alone
// - QDR-IV deskew uses loopback read data
// - Gate before read deskew, every group's bit passes
// - DDR gate: reads with a gap cycle, sweep gate
// - No pattern: bump valid FIFO, retry
// - SRAM gate: write zeros, ones, then read
// - SRAM gate: tracking on, cycle sweep
// - Read deskew runs twice, same read probe both times
// - First read deskew finishes before write leveling
// - Strobe sweep right edge, data left, center
// - Reference sweep from start, keep widest
// - Latency covers slowest group plus sync
// - Write leveling staggers data, one bit
// - QDR II skips write leveling
// - Write deskew keeps strobe output delays
// - DDR4 calibrates memory reference level
// - All groups calibrate together
// - Hand control to controller when done
`timescale 1ns/1ps
module micsq_seq
  import micsq_pkg::*;
(
  // Sequencer clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Link clock of the memory side probe logic.
  input wire logic link_clock,
  // Control.
  input wire logic start,
  input wire micsq_proto_t proto,
  // Memory side pins, sampled in the link domain.
  input wire logic [GROUPS-1:0] strobe_in,
  input wire logic [GROUPS-1:0] data_bit,
  input wire logic alert_n,
  // Memory side command outputs, link domain; data_stagger follows the sequencer stage.
  output micsq_cmd_t cmd,
  output logic strobe_gate_enable,
  output logic [GROUPS-1:0] data_stagger,
  // Delay settings.
  output micsq_dly_t dly,
  output logic [CYC_W-1:0] valid_window_fifo,
  output logic [CYC_W-1:0] read_latency_fifo,
  output logic strobe_tracking,
  output logic loopback,
  // Status.
  output micsq_stage_t stage,
  output logic cal_done,
  output logic cal_fail,
  output logic ctrl_handoff
);

  // Sequencer state.
  micsq_stage_t stage_q;
  // Sweep index and sub phase of the current stage.
  logic [DLY_W-1:0] tap_q;
  logic [1:0] phase_q;
  // Edge found by the first half of a two-edge sweep.
  logic [DLY_W-1:0] edge_q;
  // Best window seen in a reference sweep and its level.
  logic [DLY_W-1:0] best_w_q;
  logic [VREF_W-1:0] best_v_q;
  // Window edges of the current reference level.
  logic [DLY_W-1:0] lo_q;
  logic seen_q;
  // Delay registers and cycle settings.
  micsq_dly_t dly_q;
  logic [CYC_W-1:0] valid_window_fifo_q;
  logic [CYC_W-1:0] lat_q;
  // Probe request toggle and its returning acknowledge.
  logic req_q;
  logic [1:0] ack_sync_q;
  logic ack_seen_q;
  logic [1:0] pass_sync_q;
  // Probe kind register, unused; the link side decodes the stage directly.
  logic [2:0] kind_q;

  // Returns high for the DDR protocols, DDR3 and DDR4.
  function automatic logic is_ddr(input micsq_proto_t p);
    is_ddr = (p == MICSQ_DDR3) || (p == MICSQ_DDR4);
  endfunction

  // Picks the stage following a given one for the protocol.
  function automatic micsq_stage_t next_stage(input micsq_stage_t s, input micsq_proto_t p);
    next_stage = ST_DONE;
    case (s)
      ST_CA_LEVEL: begin
        next_stage = (p == MICSQ_DDR4 || p == MICSQ_QDR4) ? ST_CA_DESKEW : ST_GATE;
      end
      ST_CA_DESKEW: begin
        next_stage = ST_GATE;
      end
      ST_GATE: begin
        next_stage = ST_RD_DESKEW1;
      end
      ST_RD_DESKEW1: begin
        next_stage = (p == MICSQ_DDR4 || p == MICSQ_QDR4) ? ST_VREF_IN : ST_LAT;
      end
      ST_VREF_IN: begin
        next_stage = ST_LAT;
      end
      ST_LAT: begin
        next_stage = (p == MICSQ_QDR2) ? ST_WR_DESKEW : ST_WR_LEVEL;
      end
      ST_WR_LEVEL: begin
        next_stage = ST_WR_DESKEW;
      end
      ST_WR_DESKEW: begin
        next_stage = ST_RD_DESKEW2;
      end
      ST_RD_DESKEW2: begin
        next_stage = (p == MICSQ_DDR4) ? ST_VREF_OUT : ST_DONE;
      end
      default: begin
        next_stage = ST_DONE;
      end
    endcase
  endfunction

  // Probe result crosses from the link domain in two flops.
  logic probe_ack;
  logic probe_pass;
  assign probe_ack = ack_sync_q[1] ^ ack_seen_q;
  assign probe_pass = pass_sync_q[1];

  // Window width of a sweep between a left and a right edge.
  logic [DLY_W-1:0] width;
  assign width = tap_q - lo_q;

  // Main sequencing: one probe per tap, all groups share the result.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_q <= ST_IDLE;
      tap_q <= '0;
      phase_q <= '0;
      edge_q <= '0;
      best_w_q <= '0;
      best_v_q <= '0;
      lo_q <= '0;
      seen_q <= 1'b0;
      dly_q <= '0;
      valid_window_fifo_q <= '0;
      lat_q <= '0;
      req_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      if (stage_q == ST_IDLE) begin
        // Leveling only for DDR, otherwise straight to deskew or gate.
        if (start) begin
          stage_q <= is_ddr(proto) ? ST_CA_LEVEL : next_stage(ST_CA_LEVEL, proto);
          req_q <= ~req_q;
          tap_q <= '0;
          phase_q <= '0;
          dly_q.vref_in <= VREF_START;
          dly_q.vref_out <= VREF_START;
        end
      end else if (stage_q != ST_DONE && stage_q != ST_FAIL && probe_ack) begin
        ack_seen_q <= ~ack_seen_q;
        req_q <= ~req_q;
        tap_q <= tap_q + 6'h01;
        case (stage_q)
          // Command bus delay swept until commands are accepted.
          ST_CA_LEVEL, ST_CA_DESKEW: begin
            dly_q.ca <= tap_q;
            if (probe_pass) begin
              dly_q.ca <= tap_q;
              stage_q <= next_stage(stage_q, proto);
              tap_q <= '0;
            end else if (tap_q == DLY_MAX) begin
              stage_q <= ST_FAIL;
            end
          end
          // Gate sweep; a wrap moves the valid window one cycle on.
          ST_GATE: begin
            if (probe_pass) begin
              stage_q <= next_stage(stage_q, proto);
              tap_q <= '0;
              phase_q <= '0;
            end else if (tap_q == DLY_MAX) begin
              if (valid_window_fifo_q == CYC_MAX) begin
                stage_q <= ST_FAIL;
              end else begin
                valid_window_fifo_q <= valid_window_fifo_q + 4'h1;
              end
            end
          end
          // Strobe sweep finds right edge, data sweep the left, then center.
          ST_RD_DESKEW1, ST_RD_DESKEW2, ST_WR_DESKEW: begin
            if (phase_q == 2'h0) begin
              if (!probe_pass || tap_q == DLY_MAX) begin
                edge_q <= tap_q;
                phase_q <= 2'h1;
                tap_q <= '0;
              end
            end else if (probe_pass || tap_q == DLY_MAX) begin
              if (edge_q == '0 && !probe_pass) begin
                stage_q <= ST_FAIL;
              end else begin
                if (stage_q == ST_WR_DESKEW) begin
                  dly_q.data_out <= tap_q >> 1;
                end else begin
                  dly_q.strobe_in <= edge_q >> 1;
                  dly_q.data_in <= tap_q >> 1;
                end
                stage_q <= next_stage(stage_q, proto);
                phase_q <= '0;
                tap_q <= '0;
              end
            end
          end
          // Reference sweep: measure a window per level, keep the widest.
          ST_VREF_IN, ST_VREF_OUT: begin
            if (probe_pass && !seen_q) begin
              lo_q <= tap_q;
              seen_q <= 1'b1;
            end
            if (tap_q == DLY_MAX) begin
              tap_q <= '0;
              seen_q <= 1'b0;
              lo_q <= '0;
              if (seen_q && width > best_w_q) begin
                best_w_q <= width;
                best_v_q <= (stage_q == ST_VREF_IN) ? dly_q.vref_in : dly_q.vref_out;
              end
              // Phase 0 walks up from the start level, phase 1 walks down.
              if (stage_q == ST_VREF_IN) begin
                dly_q.vref_in <= (phase_q == 2'h0) ? dly_q.vref_in + 6'h01
                                                   : dly_q.vref_in - 6'h01;
              end else begin
                dly_q.vref_out <= (phase_q == 2'h0) ? dly_q.vref_out + 6'h01
                                                    : dly_q.vref_out - 6'h01;
              end
              if (phase_q == 2'h0 && ((stage_q == ST_VREF_IN ? dly_q.vref_in
                  : dly_q.vref_out) == DLY_MAX)) begin
                phase_q <= 2'h1;
                dly_q.vref_in <= (stage_q == ST_VREF_IN) ? VREF_START : dly_q.vref_in;
                dly_q.vref_out <= (stage_q == ST_VREF_OUT) ? VREF_START : dly_q.vref_out;
              end else if (phase_q == 2'h1 && ((stage_q == ST_VREF_IN ? dly_q.vref_in
                  : dly_q.vref_out) == '0)) begin
                if (best_w_q == '0) begin
                  stage_q <= ST_FAIL;
                end else begin
                  if (stage_q == ST_VREF_IN) begin
                    dly_q.vref_in <= best_v_q;
                  end else begin
                    dly_q.vref_out <= best_v_q;
                  end
                  best_w_q <= '0;
                  phase_q <= '0;
                  stage_q <= next_stage(stage_q, proto);
                end
              end
            end
          end
          // Latency is the slowest group's valid window plus crossing margin.
          ST_LAT: begin
            lat_q <= valid_window_fifo_q + LAT_SYNC;
            tap_q <= '0;
            stage_q <= next_stage(stage_q, proto);
          end
          // Write leveling moves strobe out until the data bits of all groups pass.
          ST_WR_LEVEL: begin
            dly_q.strobe_out <= tap_q;
            if (probe_pass) begin
              stage_q <= next_stage(stage_q, proto);
              tap_q <= '0;
            end else if (tap_q == DLY_MAX) begin
              stage_q <= ST_FAIL;
            end
          end
          default: begin
            stage_q <= ST_FAIL;
          end
        endcase
      end
    end
  end

  // Request toggle crossed into the link domain.
  logic [1:0] req_sync_q;
  logic req_seen_q;
  logic ack_q;
  logic pass_q;
  logic [3:0] cnt_q;
  logic [GROUPS-1:0] strobe_s1_q;
  logic [GROUPS-1:0] strobe_s2_q;
  logic [GROUPS-1:0] strobe_last_q;
  logic [GROUPS-1:0] data_s1_q;
  logic [GROUPS-1:0] data_s2_q;
  logic [1:0] alert_sync_q;
  logic [GROUPS-1:0] got_q;
  logic busy_q;
  micsq_cmd_t cmd_q;
  micsq_stage_t lstage;
  assign lstage = stage_q;

  // Crossing of the request and the memory pins into the link domain.
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      req_sync_q <= '0;
      strobe_s1_q <= '0;
      strobe_s2_q <= '0;
      data_s1_q <= '0;
      data_s2_q <= '0;
      alert_sync_q <= 2'h3;
    end else begin
      req_sync_q <= {req_sync_q[0], req_q};
      strobe_s1_q <= strobe_in;
      strobe_s2_q <= strobe_s1_q;
      data_s1_q <= data_bit;
      data_s2_q <= data_s1_q;
      alert_sync_q <= {alert_sync_q[0], alert_n};
    end
  end

  // Link side probe: drives commands, watches the pins for a pass.
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      req_seen_q <= 1'b0;
      ack_q <= 1'b0;
      pass_q <= 1'b0;
      cnt_q <= '0;
      got_q <= '0;
      busy_q <= 1'b0;
      strobe_last_q <= '0;
      cmd_q <= '{cs_n: 1'b1, cas_n: 1'b1, default: 1'b0};
    end else begin
      strobe_last_q <= strobe_s2_q;
      cmd_q <= '0;
      cmd_q.cs_n <= 1'b1;
      cmd_q.cas_n <= 1'b1;
      if (!busy_q && (req_sync_q[1] != req_seen_q)) begin
        busy_q <= 1'b1;
        req_seen_q <= req_sync_q[1];
        cnt_q <= '0;
        got_q <= '0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        case (lstage)
          // Read commands by select and CAS; strobe toggling is acceptance.
          ST_CA_LEVEL: begin
            cmd_q.cs_n <= cnt_q[0];
            cmd_q.cas_n <= cnt_q[0];
            got_q <= got_q | (strobe_s2_q ^ strobe_last_q);
          end
          // Parity pulse answered by alert, or loopback data.
          ST_CA_DESKEW: begin
            cmd_q.par <= cnt_q[0];
            got_q <= got_q | (proto == MICSQ_DDR4 ? {GROUPS{~alert_sync_q[1]}}
                                                  : data_s2_q);
          end
          // Reads with a gap cycle; SRAM protocols write 0s then 1s first.
          default: begin
            if (!is_ddr(proto) && cnt_q < 4'h2) begin
              cmd_q.wr <= 1'b1;
              cmd_q.wr_ones <= cnt_q[0];
            end else begin
              cmd_q.rd <= ~cnt_q[0];
              got_q <= got_q | data_s2_q;
            end
          end
        endcase
        if (cnt_q == PROBE_LEN) begin
          busy_q <= 1'b0;
          ack_q <= ~ack_q;
          pass_q <= &(got_q | data_s2_q & {GROUPS{lstage != ST_CA_LEVEL}}) | (&got_q);
        end
      end
    end
  end

  // Acknowledge and result back into the sequencer domain.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_sync_q <= '0;
      pass_sync_q <= '0;
    end else begin
      ack_sync_q <= {ack_sync_q[0], ack_q};
      pass_sync_q <= {pass_sync_q[0], pass_q};
    end
  end

  // Outputs.
  assign cmd = cmd_q;
  assign dly = dly_q;
  assign valid_window_fifo = valid_window_fifo_q;
  assign read_latency_fifo = lat_q;
  assign stage = stage_q;
  assign strobe_gate_enable = busy_q;
  assign data_stagger = (stage_q == ST_WR_LEVEL) ? 4'h5 : 4'h0;
  assign strobe_tracking = !is_ddr(proto) && stage_q != ST_IDLE;
  assign loopback = (proto == MICSQ_QDR4) && (stage_q == ST_CA_DESKEW);
  assign cal_done = (stage_q == ST_DONE);
  assign cal_fail = (stage_q == ST_FAIL);
  assign ctrl_handoff = (stage_q == ST_DONE);

  // Failure never hands off.
  chk_fail_no_handoff: assert property (@(posedge clock) disable iff (rst)
    cal_fail |-> !ctrl_handoff) else $error("handoff during failure");
  // QDR II never enters write leveling.
  chk_qdr2_skip_wl: assert property (@(posedge clock) disable iff (rst)
    (proto == MICSQ_QDR2) |-> stage_q != ST_WR_LEVEL) else $error("qdr2 leveled");
  // Leveling only for DDR.
  chk_ca_level_ddr: assert property (@(posedge clock) disable iff (rst)
    stage_q == ST_CA_LEVEL |-> is_ddr(proto)) else $error("leveling on sram");
  // Gate stage moves only to read deskew or to failure.
  chk_gate_order: assert property (@(posedge clock) disable iff (rst)
    $past(stage_q) == ST_GATE && stage_q != ST_GATE |-> stage_q inside {ST_RD_DESKEW1, ST_FAIL})
    else $error("gate order");
  // Latency covers the valid window plus margin.
  chk_lat_margin: assert property (@(posedge clock) disable iff (rst)
    stage_q == ST_WR_LEVEL |-> lat_q == valid_window_fifo_q + LAT_SYNC) else $error("latency short");
  // Write leveling only after read deskew.
  chk_rd_before_wl: assert property (@(posedge clock) disable iff (rst)
    $past(stage_q) != ST_WR_LEVEL && stage_q == ST_WR_LEVEL |-> $past(stage_q) == ST_LAT)
    else $error("leveling early");
  // Loopback only in QDR-IV deskew.
  chk_loopback_use: assert property (@(posedge clock) disable iff (rst)
    loopback |-> stage_q == ST_CA_DESKEW) else $error("loopback misuse");
  // Memory reference only on DDR4.
  chk_vref_out_ddr4: assert property (@(posedge clock) disable iff (rst)
    stage_q == ST_VREF_OUT |-> proto == MICSQ_DDR4) else $error("vref out wrong proto");

endmodule

// [include/micsq_pkg.sv]
// Package with the calibration sequencer's types and constants.
package micsq_pkg;

  // Memory protocol selector.
  typedef enum logic [2:0] {
    MICSQ_DDR3,
    MICSQ_DDR4,
    MICSQ_RLDRAM,
    MICSQ_QDR4,
    MICSQ_QDR2
  } micsq_proto_t;

  // Calibration stage, also reported as status.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CA_LEVEL,
    ST_CA_DESKEW,
    ST_GATE,
    ST_RD_DESKEW1,
    ST_VREF_IN,
    ST_LAT,
    ST_WR_LEVEL,
    ST_WR_DESKEW,
    ST_RD_DESKEW2,
    ST_VREF_OUT,
    ST_DONE,
    ST_FAIL
  } micsq_stage_t;

  // Width of every delay tap setting.
  localparam int DLY_W = 6;
  // Number of read strobe groups calibrated side by side.
  localparam int GROUPS = 4;
  // Width of the valid-window and latency settings.
  localparam int CYC_W = 4;
  // Width of the reference level setting.
  localparam int VREF_W = 6;
  // Last tap of a delay sweep.
  localparam logic [DLY_W-1:0] DLY_MAX = 6'h3F;
  // Last valid-window cycle before the gate search gives up.
  localparam logic [CYC_W-1:0] CYC_MAX = 4'hF;
  // Arbitrary starting reference level.
  localparam logic [VREF_W-1:0] VREF_START = 6'h20;
  // Extra latency for crossing the read FIFOs.
  localparam logic [CYC_W-1:0] LAT_SYNC = 4'h2;
  // Cycles of link clock per probe before its result is looked at.
  localparam logic [3:0] PROBE_LEN = 4'h8;

  // Command group driven to the memory.
  typedef struct packed {
    logic cs_n;
    logic cas_n;
    logic par;
    logic rd;
    logic wr;
    logic wr_ones;
  } micsq_cmd_t;

  // Delay settings handed to the I/O.
  typedef struct packed {
    logic [DLY_W-1:0] ca;
    logic [DLY_W-1:0] strobe_in;
    logic [DLY_W-1:0] data_in;
    logic [DLY_W-1:0] strobe_out;
    logic [DLY_W-1:0] data_out;
    logic [VREF_W-1:0] vref_in;
    logic [VREF_W-1:0] vref_out;
  } micsq_dly_t;

endpackage

// [bench/micsq_mem_model.sv]
// Behavioural memory device that answers the sequencer's calibration probes.
`timescale 1ns/1ps
module micsq_mem_model
  import micsq_pkg::*;
(
  // Link clock and reset.
  input wire logic link_clock,
  input wire logic rst,
  // Behaviour chosen by the bench: answer correctly, answer late.
  input wire logic good,
  input wire logic slow,
  // Pins from the sequencer.
  input wire micsq_cmd_t cmd,
  input wire logic loopback,
  // Pins back to the sequencer.
  output logic [GROUPS-1:0] strobe_in,
  output logic [GROUPS-1:0] data_bit,
  output logic alert_n
);
  // History of reads seen, so the answer trails the command.
  logic [3:0] rd_pipe_q;
  // History of parity bits seen, for the alert answer.
  logic [3:0] par_pipe_q;
  // A read is a select and CAS pair, or an explicit read.
  logic read_cmd;
  // Answer moments for the chosen latency.
  logic rd_hit;
  logic par_hit;
  assign read_cmd = cmd.rd | (~cmd.cs_n & ~cmd.cas_n);
  assign rd_hit = slow ? rd_pipe_q[1] : rd_pipe_q[0];
  assign par_hit = slow ? par_pipe_q[1] : par_pipe_q[0];

  // Shift the command history once per link cycle.
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      rd_pipe_q <= 4'h0;
      par_pipe_q <= 4'h0;
    end else begin
      rd_pipe_q <= {rd_pipe_q[2:0], read_cmd};
      par_pipe_q <= {par_pipe_q[2:0], cmd.par};
    end
  end

  // Drive strobe, data and alert; released lines never hold a stale value.
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      strobe_in <= 4'h0;
      data_bit <= 4'h0;
      alert_n <= 1'b1;
    end else begin
      // A correct device toggles its strobes while returning read data.
      strobe_in <= (good && rd_hit) ? ~strobe_in : 4'h0;
      if (loopback) begin
        // Loopback returns the captured command lines on the data pins.
        data_bit <= good ? {cmd.par, cmd.par, cmd.cas_n, cmd.cs_n} : 4'h0;
      end else if (good && rd_hit) begin
        // Read data of ones on every group.
        data_bit <= 4'hF;
      end else begin
        // Released data lines show the inverse of what they last showed.
        data_bit <= good ? ~data_bit : 4'h0;
      end
      // Alert pulls low after a parity bit; the pull-up holds it high otherwise.
      alert_n <= ~(good && par_hit && !loopback);
    end
  end
endmodule

// [bench/micsq_seq_tb.sv]
// Self-checking testbench for the calibration sequencer.
`timescale 1ns/1ps
module micsq_seq_tb
  import micsq_pkg::*;
();
  // Stimulus driven by the bench.
  logic clock = 1'b0;
  logic link_clock = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  micsq_proto_t proto = MICSQ_DDR3;
  logic good = 1'b1;
  logic slow = 1'b0;
  // Outputs of the sequencer and of the memory model.
  micsq_cmd_t cmd;
  logic strobe_gate_enable;
  logic [GROUPS-1:0] data_stagger;
  logic [GROUPS-1:0] strobe_in;
  logic [GROUPS-1:0] data_bit;
  logic alert_n;
  micsq_dly_t dly;
  logic [CYC_W-1:0] valid_window_fifo;
  logic [CYC_W-1:0] read_latency_fifo;
  logic strobe_tracking;
  logic loopback;
  micsq_stage_t stage;
  logic cal_done;
  logic cal_fail;
  logic ctrl_handoff;
  // Counters of the run.
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Stages seen in order since the last reset.
  micsq_stage_t seen_q[$];
  micsq_stage_t last_q = ST_IDLE;
  // Observations gathered while calibration runs.
  logic stag_bad = 1'b0;
  logic out_moved = 1'b0;
  logic early_ho = 1'b0;
  logic saw_track = 1'b0;
  logic saw_loop = 1'b0;
  logic saw_par = 1'b0;
  logic saw_wr = 1'b0;
  logic [DLY_W-1:0] out_hold = '0;

  micsq_seq dut (
    .clock(clock), .rst(rst), .link_clock(link_clock), .start(start), .proto(proto),
    .strobe_in(strobe_in), .data_bit(data_bit), .alert_n(alert_n), .cmd(cmd),
    .strobe_gate_enable(strobe_gate_enable), .data_stagger(data_stagger), .dly(dly),
    .valid_window_fifo(valid_window_fifo), .read_latency_fifo(read_latency_fifo),
    .strobe_tracking(strobe_tracking), .loopback(loopback), .stage(stage),
    .cal_done(cal_done), .cal_fail(cal_fail), .ctrl_handoff(ctrl_handoff)
  );

  micsq_mem_model mem (
    .link_clock(link_clock), .rst(rst), .good(good), .slow(slow), .cmd(cmd),
    .loopback(loopback), .strobe_in(strobe_in), .data_bit(data_bit), .alert_n(alert_n)
  );

  // Sequencer clock, 100 ns period.
  initial begin
    forever #50 clock = ~clock;
  end

  // Link clock, 12 ns period, offset so its edges never meet the other clock's.
  initial begin
    #3;
    forever #6 link_clock = ~link_clock;
  end

  // Watch the stage sequence and the outputs that depend on the stage.
  always @(negedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      stop_test();
    end
    if (!rst && stage !== last_q) begin
      seen_q.push_back(stage);
      last_q = stage;
      out_hold = dly.strobe_out;
    end
    if (!rst) begin
      if (data_stagger !== ((stage === ST_WR_LEVEL) ? 4'h5 : 4'h0)) stag_bad = 1'b1;
      if (stage === ST_WR_DESKEW && dly.strobe_out !== out_hold) out_moved = 1'b1;
      if (ctrl_handoff !== 1'b0 && stage !== ST_DONE) early_ho = 1'b1;
      if (stage === ST_GATE && strobe_tracking === 1'b1) saw_track = 1'b1;
      if (stage === ST_CA_DESKEW && loopback === 1'b1) saw_loop = 1'b1;
    end
  end

  // Parity is a link-side pin, so it is watched on the link clock.
  always @(negedge link_clock) begin
    if (!rst && stage === ST_CA_DESKEW && cmd.par === 1'b1) saw_par = 1'b1;
    if (!rst && stage === ST_GATE && cmd.wr === 1'b1 && cmd.wr_ones === 1'b1) saw_wr = 1'b1;
  end

  // Compare one flag.
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Compare one small count or vector.
  task automatic chk_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare one stage.
  task automatic chk_stage(input string nm, input micsq_stage_t e, input micsq_stage_t g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Reset both domains for two sequencer cycles and clear the observations.
  task automatic do_reset();
    @(posedge clock);
    #1 rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    seen_q = {};
    last_q = ST_IDLE;
    {stag_bad, out_moved, early_ho, saw_track, saw_loop, saw_par, saw_wr} = 7'h00;
  endtask

  // Raise start for one cycle, just after an edge.
  task automatic pulse_start();
    @(posedge clock);
    #1 start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
  endtask

  // Wait under a bound for calibration to finish either way.
  task automatic wait_end();
    int n;
    n = 0;
    while (cal_done !== 1'b1 && cal_fail !== 1'b1 && n < 40000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 40000) begin
      mismatches++;
      $display("CHECK FAILED calibration end expected 1 seen 0");
      stop_test();
    end
    @(posedge clock);
    #1;
  endtask

  // Outputs right after reset.
  task automatic test_reset();
    do_reset();
    @(posedge clock);
    #1;
    chk_stage("stage after reset", ST_IDLE, stage);
    chk_bit("done after reset", 1'b0, cal_done);
    chk_bit("handoff after reset", 1'b0, ctrl_handoff);
    chk_bit("select idle", 1'b1, cmd.cs_n);
    chk_bit("gate after reset", 1'b0, strobe_gate_enable);
    chk_vec("latency after reset", 8'h00, {4'h0, read_latency_fifo});
    $display("test reset done");
  endtask

  // Full calibration of one protocol, with a start repeated in mid-run.
  task automatic run_cal(input micsq_proto_t p, input logic slow_mode);
    micsq_stage_t exp_q[$];
    logic sram;
    sram = (p == MICSQ_RLDRAM || p == MICSQ_QDR4 || p == MICSQ_QDR2);
    exp_q = {};
    if (p == MICSQ_DDR3 || p == MICSQ_DDR4) exp_q.push_back(ST_CA_LEVEL);
    if (p == MICSQ_DDR4 || p == MICSQ_QDR4) exp_q.push_back(ST_CA_DESKEW);
    exp_q.push_back(ST_GATE);
    exp_q.push_back(ST_RD_DESKEW1);
    if (p == MICSQ_DDR4 || p == MICSQ_QDR4) exp_q.push_back(ST_VREF_IN);
    exp_q.push_back(ST_LAT);
    if (p != MICSQ_QDR2) exp_q.push_back(ST_WR_LEVEL);
    exp_q.push_back(ST_WR_DESKEW);
    exp_q.push_back(ST_RD_DESKEW2);
    if (p == MICSQ_DDR4) exp_q.push_back(ST_VREF_OUT);
    exp_q.push_back(ST_DONE);
    proto = p;
    slow = slow_mode;
    good = 1'b1;
    do_reset();
    pulse_start();
    repeat (20) @(posedge clock);
    pulse_start();
    wait_end();
    chk_bit("done", 1'b1, cal_done);
    chk_bit("fail", 1'b0, cal_fail);
    chk_bit("handoff", 1'b1, ctrl_handoff);
    chk_bit("early handoff", 1'b0, early_ho);
    chk_vec("stage count", 8'(exp_q.size()), 8'(seen_q.size()));
    for (int i = 0; i < exp_q.size(); i++) begin
      chk_stage("stage order", exp_q[i], seen_q[i]);
    end
    chk_bit("stagger", 1'b0, stag_bad);
    chk_bit("strobe out hold", 1'b0, out_moved);
    chk_bit("tracking", sram, saw_track);
    chk_bit("loopback", p == MICSQ_QDR4, saw_loop);
    if (p == MICSQ_DDR4) chk_bit("parity sent", 1'b1, saw_par);
    chk_vec("latency margin", 8'(valid_window_fifo + LAT_SYNC), {4'h0, read_latency_fifo});
    chk_vec("vref in", 8'(VREF_START), 8'(dly.vref_in));
    chk_vec("vref out", 8'(VREF_START), 8'(dly.vref_out));
    chk_vec("strobe in center", 8'(DLY_MAX >> 1), 8'(dly.strobe_in));
    chk_bit("ones write", sram, saw_wr);
    $display("test calibration protocol %0d done", p);
  endtask

  // A device that never answers: calibration stops at the first stage.
  task automatic test_fail();
    proto = MICSQ_DDR3;
    slow = 1'b0;
    good = 1'b0;
    do_reset();
    pulse_start();
    wait_end();
    chk_bit("fail flag", 1'b1, cal_fail);
    chk_bit("done on fail", 1'b0, cal_done);
    chk_bit("handoff on fail", 1'b0, ctrl_handoff);
    chk_stage("fail stage", ST_FAIL, stage);
    chk_stage("stage before fail", ST_CA_LEVEL, seen_q[0]);
    chk_vec("stages on fail", 8'h02, 8'(seen_q.size()));
    $display("test failure done");
  endtask

  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    test_reset();
    run_cal(MICSQ_DDR3, 1'b0);
    run_cal(MICSQ_DDR4, 1'b1);
    run_cal(MICSQ_RLDRAM, 1'b0);
    run_cal(MICSQ_QDR4, 1'b1);
    run_cal(MICSQ_QDR2, 1'b0);
    test_fail();
    stop_test();
  end
endmodule
